/* File: rtl/msd_pkg.sv */
package msd_pkg;
  // region bounds of the 16-bit program space and the 8-bit data space; defaults are plain
  localparam logic [15:0] ROM_LIMIT = 16'h4000;
  localparam logic [15:0] PRAM_BASE = 16'hC000;
  localparam logic [7:0] UPPER_BASE = 8'h80;
  localparam logic [3:0] WAIT_RST = 4'h0;
  localparam logic [3:0] WAIT_ZERO = 4'h0;
  localparam logic [3:0] WAIT_ONE = 4'h1;

  typedef enum logic [1:0] {
    MSD_TGT_ROM = 2'b00,
    MSD_TGT_PRAM = 2'b01,
    MSD_TGT_EXT = 2'b10
  } msd_target_t;

  typedef enum logic [1:0] {
    MSD_IDLE = 2'b00,
    MSD_WAIT = 2'b01,
    MSD_DONE = 2'b10
  } msd_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } msd_dacc_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } msd_usr_t;
endpackage : msd_pkg

/* File: rtl/msd_wait_ctr.sv */
`timescale 1ns/1ps
`default_nettype none
module msd_wait_ctr
  import msd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // control
  input wire logic start_i,
  input wire logic [3:0] count_i,
  input wire logic hold_i,
  // status
  output logic done_o
);
  logic [3:0] remain;
  logic busy;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      remain <= WAIT_ZERO;
      busy <= 1'b0;
    end else if (start_i) begin
      remain <= count_i;
      busy <= 1'b1;
    end else if (busy && !hold_i) begin
      if (remain == WAIT_ZERO) begin
        busy <= 1'b0;
      end else begin
        remain <= remain - WAIT_ONE;
      end
    end
  end

  // external wait request freezes completion
  assign done_o = busy && !hold_i && (remain == WAIT_ZERO);
endmodule : msd_wait_ctr
`default_nettype wire

/* File: rtl/msd_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module msd_decoder
  import msd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // wait configuration from software
  input wire logic [3:0] prog_wait_i,
  input wire logic [3:0] xdata_wait_i,
  // program access request
  input wire logic fetch_req_i,
  input wire logic pwrite_req_i,
  input wire logic [15:0] prog_addr_i,
  input wire logic [7:0] prog_wdata_i,
  // internal data / direct access request
  input wire logic idata_req_i,
  input wire logic direct_i,
  input wire logic core_reg_hit_i,
  input wire msd_dacc_t idata_i,
  // external data request
  input wire logic xdata_req_i,
  input wire logic xdata_wr_i,
  input wire logic [15:0] xdata_addr_i,
  input wire logic [7:0] xdata_wdata_i,
  // memory side
  input wire logic mem_wait_i,
  input wire logic [7:0] rom_rdata_i,
  input wire logic [7:0] pram_rdata_i,
  input wire logic [7:0] ext_rdata_i,
  // program memory outputs
  output logic [15:0] prog_addr_o,
  output logic [7:0] prog_wdata_o,
  output logic rom_sel_o,
  output logic pram_sel_o,
  output logic ext_sel_o,
  output logic prog_wr_o,
  output logic [7:0] fetch_data_o,
  output logic fetch_valid_o,
  // internal data memory outputs
  output msd_dacc_t idata_o,
  // user register port
  output msd_usr_t usr_o,
  // external data outputs
  output logic [15:0] xdata_addr_o,
  output logic [7:0] xdata_wdata_o,
  output logic xdata_rd_o,
  output logic xdata_wr_o,
  output logic xdata_done_o,
  // core stall
  output logic stall_o
);
  msd_state_t pstate;
  msd_state_t xstate;
  msd_target_t ptgt;
  logic pdone;
  logic xdone;
  logic pstart;
  logic xstart;

  function automatic msd_target_t decode_prog(input logic [15:0] a);
    if (a < ROM_LIMIT) begin
      return MSD_TGT_ROM;
    end else if (a >= PRAM_BASE) begin
      return MSD_TGT_PRAM;
    end else begin
      return MSD_TGT_EXT;
    end
  endfunction : decode_prog

  function automatic logic is_user(input logic d, input logic hit,
                                   input logic [7:0] a);
    return d && !hit && (a >= UPPER_BASE);
  endfunction : is_user

  assign pstart = (pstate == MSD_IDLE) && (fetch_req_i || pwrite_req_i);
  assign xstart = (xstate == MSD_IDLE) && xdata_req_i;

  msd_wait_ctr u_pwait (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .start_i(pstart),
    .count_i(prog_wait_i),
    .hold_i(mem_wait_i),
    .done_o(pdone)
  );

  msd_wait_ctr u_xwait (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .start_i(xstart),
    .count_i(xdata_wait_i),
    .hold_i(mem_wait_i),
    .done_o(xdone)
  );

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pstate <= MSD_IDLE;
      ptgt <= MSD_TGT_ROM;
      prog_addr_o <= 16'h0000;
      prog_wdata_o <= 8'h00;
      rom_sel_o <= 1'b0;
      pram_sel_o <= 1'b0;
      ext_sel_o <= 1'b0;
      prog_wr_o <= 1'b0;
      fetch_data_o <= 8'h00;
      fetch_valid_o <= 1'b0;
    end else begin
      fetch_valid_o <= 1'b0;
      prog_wr_o <= 1'b0;
      unique case (pstate)
        MSD_IDLE: begin
          if (pstart) begin
            ptgt <= decode_prog(prog_addr_i);
            prog_addr_o <= prog_addr_i;
            prog_wdata_o <= prog_wdata_i;
            rom_sel_o <= decode_prog(prog_addr_i) == MSD_TGT_ROM;
            pram_sel_o <= decode_prog(prog_addr_i) == MSD_TGT_PRAM;
            ext_sel_o <= decode_prog(prog_addr_i) == MSD_TGT_EXT;
            prog_wr_o <= pwrite_req_i;
            pstate <= MSD_WAIT;
          end
        end
        MSD_WAIT: begin
          if (pdone) begin
            unique case (ptgt)
              MSD_TGT_ROM: fetch_data_o <= rom_rdata_i;
              MSD_TGT_PRAM: fetch_data_o <= pram_rdata_i;
              default: fetch_data_o <= ext_rdata_i;
            endcase
            fetch_valid_o <= 1'b1;
            rom_sel_o <= 1'b0;
            pram_sel_o <= 1'b0;
            ext_sel_o <= 1'b0;
            pstate <= MSD_DONE;
          end
        end
        MSD_DONE: begin
          pstate <= MSD_IDLE;
        end
        default: begin
          pstate <= MSD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      xstate <= MSD_IDLE;
      xdata_addr_o <= 16'h0000;
      xdata_wdata_o <= 8'h00;
      xdata_rd_o <= 1'b0;
      xdata_wr_o <= 1'b0;
      xdata_done_o <= 1'b0;
    end else begin
      xdata_done_o <= 1'b0;
      unique case (xstate)
        MSD_IDLE: begin
          if (xstart) begin
            xdata_addr_o <= xdata_addr_i;
            xdata_wdata_o <= xdata_wdata_i;
            xdata_rd_o <= !xdata_wr_i;
            xdata_wr_o <= xdata_wr_i;
            xstate <= MSD_WAIT;
          end
        end
        MSD_WAIT: begin
          if (xdone) begin
            xdata_rd_o <= 1'b0;
            xdata_wr_o <= 1'b0;
            xdata_done_o <= 1'b1;
            xstate <= MSD_DONE;
          end
        end
        MSD_DONE: begin
          xstate <= MSD_IDLE;
        end
        default: begin
          xstate <= MSD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      idata_o <= '0;
    end else begin
      idata_o.addr <= idata_i.addr;
      idata_o.wdata <= idata_i.wdata;
      idata_o.wr <= idata_req_i && idata_i.wr &&
                    !is_user(direct_i, core_reg_hit_i, idata_i.addr);
      idata_o.rd <= idata_req_i && idata_i.rd && !idata_i.wr &&
                    !is_user(direct_i, core_reg_hit_i, idata_i.addr);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      usr_o <= '0;
    end else begin
      usr_o.addr <= idata_i.addr[6:0];
      usr_o.wdata <= idata_i.wdata;
      usr_o.wr <= idata_req_i && idata_i.wr &&
                  is_user(direct_i, core_reg_hit_i, idata_i.addr);
      usr_o.rd <= idata_req_i && idata_i.rd && !idata_i.wr &&
                  is_user(direct_i, core_reg_hit_i, idata_i.addr);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stall_o <= 1'b0;
    end else begin
      stall_o <= mem_wait_i || (pstart || (pstate == MSD_WAIT && !pdone))
                 || (xstart || (xstate == MSD_WAIT && !xdone));
    end
  end
endmodule : msd_decoder
`default_nettype wire

/* File: bench/msd_chk_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module msd_chk
  import msd_pkg::*;
(
  // clock, reset and causes
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] prog_wait_i,
  input wire logic mem_wait_i,
  input wire msd_dacc_t idata_i,
  // watched outputs
  input wire logic [15:0] prog_addr_o,
  input wire logic rom_sel_o,
  input wire logic pram_sel_o,
  input wire logic ext_sel_o,
  input wire logic prog_wr_o,
  input wire logic fetch_valid_o,
  input wire msd_dacc_t idata_o,
  input wire msd_usr_t usr_o,
  input wire logic stall_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence sel_up;
    $rose(rom_sel_o || pram_sel_o || ext_sel_o);
  endsequence
  sequence plain;
    prog_wait_i == WAIT_ZERO && !mem_wait_i && !prog_wr_o;
  endsequence
  rom_range_a: assert property (rom_sel_o |->
    prog_addr_o < ROM_LIMIT)
    else $error("rom select out of range");
  pram_range_a: assert property (pram_sel_o |->
    prog_addr_o >= PRAM_BASE)
    else $error("program ram select out of range");
  ext_range_a: assert property (ext_sel_o |->
    prog_addr_o >= ROM_LIMIT && prog_addr_o < PRAM_BASE)
    else $error("external select out of range");
  fetch_time_a: assert property (sel_up ##0 plain |=> fetch_valid_o)
    else $error("fetch answer late");
  pwr_pulse_a: assert property (prog_wr_o |=> !prog_wr_o)
    else $error("program write strobe too long");
  usr_addr_a: assert property ((usr_o.rd || usr_o.wr) |->
    usr_o.addr == $past(idata_i.addr[6:0]) &&
    $past(idata_i.addr) >= UPPER_BASE)
    else $error("user register address wrong");
  rd_wr_a: assert property (!(idata_o.rd && idata_o.wr))
    else $error("data read and write together");
  wait_stall_a: assert property (mem_wait_i |=> stall_o)
    else $error("no stall under wait");
endmodule : msd_chk
`default_nettype wire

/* File: bench/msd_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module msd_mem_model (
  // from the decoder
  input wire logic sys_clk_i,
  input wire logic slow_i,
  input wire logic rom_sel_i,
  input wire logic pram_sel_i,
  input wire logic ext_sel_i,
  input wire logic [15:0] addr_i,
  // answers
  output logic [7:0] rom_rdata_o,
  output logic [7:0] pram_rdata_o,
  output logic [7:0] ext_rdata_o,
  output logic wait_o
);
  logic [7:0] junk = 8'h00;
  logic [2:0] wcnt = 3'h0;
  always_ff @(posedge sys_clk_i) junk <= junk + 8'h35;
  always_ff @(posedge sys_clk_i) wcnt <= ext_sel_i ? wcnt + 3'h1 : 3'h0;
  // unselected memories show a changing pattern, not stale data
  assign rom_rdata_o = rom_sel_i ? addr_i[7:0] : junk;
  assign pram_rdata_o = pram_sel_i ? ~addr_i[7:0] : junk;
  assign ext_rdata_o = ext_sel_i ? addr_i[15:8] : junk;
  assign wait_o = slow_i && ext_sel_i && wcnt < 3'h2;
endmodule : msd_mem_model
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import msd_pkg::*;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, slow = 1'b0;
  logic [3:0] prog_wait_i = 4'h0, xdata_wait_i = 4'h0;
  logic fetch_req_i = 1'b0, pwrite_req_i = 1'b0, idata_req_i = 1'b0;
  logic direct_i = 1'b0, core_reg_hit_i = 1'b0, xdata_req_i = 1'b0;
  logic xdata_wr_i = 1'b0, mem_wait_i, prog_wr_o, fetch_valid_o;
  logic [15:0] prog_addr_i = 16'h0000, xdata_addr_i = 16'h0000;
  logic [7:0] prog_wdata_i = 8'h00, xdata_wdata_i = 8'h00, got;
  logic [7:0] rom_rdata_i, pram_rdata_i, ext_rdata_i, fetch_data_o;
  logic [15:0] prog_addr_o, xdata_addr_o;
  logic [7:0] prog_wdata_o, xdata_wdata_o;
  logic rom_sel_o, pram_sel_o, ext_sel_o, stall_o, seen_wr;
  logic xdata_rd_o, xdata_wr_o, xdata_done_o;
  msd_dacc_t idata_i = '0, idata_o;
  msd_usr_t usr_o;
  logic [2:0] seen_sel;
  logic [31:0] seen_x;
  int n_fail = 0, checks = 0, n;
  msd_decoder DUT (.*);
  msd_mem_model mem (.sys_clk_i(sys_clk_i), .slow_i(slow),
    .rom_sel_i(rom_sel_o), .pram_sel_i(pram_sel_o), .ext_sel_i(ext_sel_o),
    .addr_i(prog_addr_o), .rom_rdata_o(rom_rdata_i),
    .pram_rdata_o(pram_rdata_i), .ext_rdata_o(ext_rdata_i),
    .wait_o(mem_wait_i));
  always #20 sys_clk_i = ~sys_clk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // m: 0 fetch answer, 1 data done, 2 path idle
  task automatic run(input int m);
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
      fetch_req_i = 1'b0;
      pwrite_req_i = 1'b0;
      xdata_req_i = 1'b0;
      got = fetch_data_o;
      if (n == 1) begin
        seen_sel = {rom_sel_o, pram_sel_o, ext_sel_o};
        seen_wr = prog_wr_o;
        seen_x = {xdata_addr_o, xdata_wdata_o, xdata_wr_o, xdata_rd_o};
      end
      if (n > 40) begin
        n_fail++;
        finish_test();
      end
    end while (n < 2 || !(m == 0 ? fetch_valid_o : m == 1 ? xdata_done_o
      : !stall_o));
    @(negedge sys_clk_i);
  endtask : run
  task automatic fetch(input logic [15:0] a, input int cyc);
    logic up;
    logic lo;
    up = a >= PRAM_BASE;
    lo = a < ROM_LIMIT;
    prog_addr_i = a;
    fetch_req_i = 1'b1;
    run(0);
    check(seen_sel, {lo, up, !lo && !up});
    // cast keeps the inverted byte from widening to the argument size
    check(got, lo ? a[7:0] : up ? 8'(~a[7:0]) : a[15:8]);
    check(seen_wr, 1'b0);
    check(n, cyc);
  endtask : fetch
  task automatic t_fetch;
    logic [15:0] a[6] = '{16'h0000, 16'h3FFF, 16'h4000, 16'hBFFF,
      16'hC000, 16'hFFFF};
    foreach (a[i]) fetch(a[i], 2);
    prog_wait_i = 4'h3;
    fetch(16'h0010, 5);
    prog_wait_i = 4'h0;
    slow = 1'b1;
    fetch(16'h5000, 4);
    slow = 1'b0;
    prog_addr_i = 16'hC005;
    prog_wdata_i = 8'h5A;
    pwrite_req_i = 1'b1;
    run(2);
    check({seen_wr, seen_sel}, 4'hA);
    check(prog_wdata_o, 8'h5A);
    $display("fetch tests done");
  endtask : t_fetch
  task automatic t_xdata;
    xdata_wait_i = 4'h2;
    xdata_addr_i = 16'hABCD;
    xdata_wdata_i = 8'h3C;
    for (int w = 0; w < 2; w++) begin
      xdata_wr_i = w[0];
      xdata_req_i = 1'b1;
      run(1);
      check(seen_x, {16'hABCD, 8'h3C, w[0], !w[0]});
      // two wait states plus the take and answer cycles
      check(n, 4);
    end
    $display("external data tests done");
  endtask : t_xdata
  task automatic t_idata;
    logic [11:0] tc[5] = '{12'h990, 12'hE81, 12'h2FF, 12'hB7F, 12'hAFF};
    logic u;
    idata_req_i = 1'b1;
    foreach (tc[i]) begin
      {direct_i, core_reg_hit_i, idata_i.rd, idata_i.wr, idata_i.addr} = tc[i];
      idata_i.wdata = ~tc[i][7:0];
      u = tc[i][11:10] == 2'b10 && tc[i][7:0] >= UPPER_BASE;
      @(negedge sys_clk_i);
      check({usr_o.rd, usr_o.wr, idata_o.rd, idata_o.wr},
        {u ? {tc[i][9] && !tc[i][8], tc[i][8]} : 2'b00,
        u ? 2'b00 : {tc[i][9] && !tc[i][8], tc[i][8]}});
      // user port shows seven bits, data memory all eight
      check(u ? usr_o.addr : idata_o.addr,
        u ? tc[i][6:0] : tc[i][7:0]);
      check({usr_o.wdata, idata_o.wdata}, {2{~tc[i][7:0]}});
    end
    idata_req_i = 1'b0;
    $display("internal data tests done");
  endtask : t_idata
  initial begin
    repeat (5) @(negedge sys_clk_i);
    rst_i = 1'b0;
    t_fetch();
    t_xdata();
    t_idata();
    finish_test();
  end
endmodule : testbench
bind msd_decoder msd_chk u_chk (.*);
`default_nettype wire
